/* File: hw/cmrp_pkg.sv */
/*
 package for the card mark read and punch retry control unit.
 assumes nothing beyond a SystemVerilog compiler.
*/
package cmrp_pkg;
    localparam logic [7:0] CMRP_SUB_CODE = 8'h3F;
    localparam logic [7:0] CMRP_BLANK = 8'h40;
    localparam int CMRP_COLS = 80;
    localparam int CMRP_SHORT_COLS = 51;
    localparam int CMRP_FLAG_COL = 80;
    localparam int CMRP_FLAG_COL_BIN = 160;
    localparam int CMRP_BUF_DEPTH = 160;
    localparam int CMRP_AW = 8;
    localparam logic [7:0] CMRP_FLAG_IDX = 8'h4F;
    localparam logic [7:0] CMRP_FLAG_IDX_BIN = 8'h9F;
    localparam logic [7:0] CMRP_LAST_IDX = 8'h4F;
    localparam logic [7:0] CMRP_LAST_IDX_BIN = 8'h9F;
    localparam logic [7:0] CMRP_SHORT_LAST = 8'h32;
    localparam logic [1:0] CMRP_STK_NORMAL = 2'h1;
    localparam logic [1:0] CMRP_STK_ERROR = 2'h3;
    localparam logic [7:0] CMRP_CMD_PFR = 8'h02;
    localparam logic [7:0] CMRP_CMD_READ = 8'h04;
    localparam logic [7:0] CMRP_CMD_WRFEED = 8'h01;
    localparam logic [7:0] CMRP_CMD_FEED = 8'h03;
    localparam logic [7:0] CMRP_CMD_MARK_FMT = 8'h05;
    localparam logic [7:0] CMRP_CMD_SKIP_FMT = 8'h07;
    // both modifier bits (format, column binary) stripped from the opcode
    localparam logic [7:0] CMRP_CMD_BASE_MASK = 8'h9F;
    localparam int CMRP_FMT_BIT = 5;
    localparam int CMRP_BIN_BIT = 6;
endpackage : cmrp_pkg

/* File: hw/cmrp_buf_mem.sv */
/*
 card image buffer: one write port, one registered read port.
 assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module cmrp_buf_mem
#(
    parameter int DEPTH = 160,
    parameter int AW = 8
)
(
    input wire logic sys_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data_ff
);
    logic [7:0] mem_ff [DEPTH];

    // no reset on storage; contents are defined by writes before use
    always_ff @(posedge sys_clk)
    begin
        if (wr_en)
        begin
            mem_ff[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem_ff[rd_addr];
    end
endmodule : cmrp_buf_mem
`default_nettype wire

/* File: hw/cmrp_ctrl.sv */
/*
 card reader / punch control unit: mark column handling into the input
 buffer, command screening, and autonomous single punch retry.
 assumes card station sensors come from logic on sys_clk, except the
 punch motion sense which arrives from pins and is synchronised here.
*/
// Summary of operation
// - unreadable mark column stores 3F, or 3F3F in column binary mode
// - any marginal mark puts 3F in column 80, or 160 in binary
// - marginal marks raise no error; flag column is the only report
// - 51-column cards fill positions 1-51, blanks elsewhere, flag at 80
// - legacy punch-feed-read command is answered with command reject
// - punch with read option accepts reader commands except mark reading
// - card passes read, punch, print stations, then one of two stackers
// - punch sensor output compared with sent data; position, skew checked
// - punch error outside read/punch sends card to stacker 3, repunches
// - good retry card to stacker 3, light on, punch another, resume
// - retry sequenced internally, invisible to channel and program
// - one retry only; second failure stops punching, reports error
// - read followed by write-and-feed on same card bypasses retry
// - read option supports column binary and column skip as standard
// - mark fields compressed; only mark columns are stored
// - mark reading only after mark format, with format bit; excludes skip
`timescale 1ns/1ps
`default_nettype none
module cmrp_ctrl
    import cmrp_pkg::*;
#(
    parameter bit HAS_MARK_READ = 1'b1,
    parameter bit HAS_READ_OPT = 1'b1
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic card_start,
    input wire logic short_card,
    input wire logic col_valid,
    input wire logic col_is_mark,
    input wire logic col_skip,
    input wire logic col_unreadable,
    input wire logic col_marginal,
    input wire logic [7:0] col_data,
    input wire logic card_end,
    input wire logic punch_done,
    input wire logic punch_sense_raw,
    input wire logic [7:0] punch_expect,
    input wire logic pos_skew_ok,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_ff,
    output logic cmd_reject_ff,
    output logic cmd_accept_ff,
    output logic punch_req_ff,
    output logic [1:0] stacker_sel_ff,
    output logic stack_req_ff,
    output logic stk3_light_ff,
    output logic punch_error_ff,
    output logic busy_ff
);
    typedef enum {ST_IDLE, ST_FILL, ST_COPY, ST_FLAG} cmrp_rd_t;
    typedef enum {PS_IDLE, PS_PUNCH, PS_RETRY, PS_EXTRA, PS_STOP} cmrp_ps_t;

    cmrp_rd_t rd_st_ff, nxt_rd_st;
    cmrp_ps_t ps_st_ff, nxt_ps_st;
    logic mark_fmt_ff, nxt_mark_fmt;
    logic skip_fmt_ff, nxt_skip_fmt;
    logic fmt_on_ff, nxt_fmt_on;
    logic bin_ff, nxt_bin;
    logic short_ff, nxt_short;
    logic marginal_ff, nxt_marginal;
    logic read_seen_ff, nxt_read_seen;
    logic bypass_ff, nxt_bypass;
    logic [7:0] wptr_ff, nxt_wptr;
    logic [7:0] fill_ff, nxt_fill;
    logic nxt_reject, nxt_accept, nxt_punch_req, nxt_stack_req;
    logic [1:0] nxt_stk;
    logic nxt_light, nxt_perr, nxt_busy;
    logic sense_s1_ff, sense_s2_ff;
    logic wr_en;
    logic [7:0] wr_addr, wr_data;
    logic [7:0] base;
    logic punch_bad;

    function automatic logic [7:0] last_idx(input logic bin, input logic sh);
        if (sh)
        begin
            return CMRP_SHORT_LAST;
        end
        return bin ? CMRP_LAST_IDX_BIN : CMRP_LAST_IDX;
    endfunction : last_idx

    cmrp_buf_mem #(.DEPTH(CMRP_BUF_DEPTH), .AW(CMRP_AW)) u_buf
    (
        .sys_clk(sys_clk),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .rd_addr(rd_addr),
        .rd_data_ff(rd_data_ff)
    );

    // punch motion sense comes from pins
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sense_s1_ff <= 1'b0;
            sense_s2_ff <= 1'b0;
        end
        else
        begin
            sense_s1_ff <= punch_sense_raw;
            sense_s2_ff <= sense_s1_ff;
        end
    end

    assign base = cmd_code & CMRP_CMD_BASE_MASK;
    // sensed hole against expected bit and registration check
    assign punch_bad = (sense_s2_ff != punch_expect[0]) || !pos_skew_ok;

    always_comb
    begin
        nxt_rd_st = rd_st_ff;
        nxt_mark_fmt = mark_fmt_ff;
        nxt_skip_fmt = skip_fmt_ff;
        nxt_fmt_on = fmt_on_ff;
        nxt_bin = bin_ff;
        nxt_short = short_ff;
        nxt_marginal = marginal_ff;
        nxt_read_seen = read_seen_ff;
        nxt_bypass = bypass_ff;
        nxt_wptr = wptr_ff;
        nxt_fill = fill_ff;
        nxt_reject = 1'b0;
        nxt_accept = 1'b0;
        wr_en = 1'b0;
        wr_addr = wptr_ff;
        wr_data = col_data;
        if (cmd_valid)
        begin
            if (base == CMRP_CMD_PFR)
            begin
                nxt_reject = 1'b1;
            end
            else if (base == CMRP_CMD_MARK_FMT)
            begin
                // without mark hardware the read option rejects it
                nxt_reject = !HAS_MARK_READ;
                nxt_accept = HAS_MARK_READ;
                nxt_mark_fmt = HAS_MARK_READ;
                nxt_skip_fmt = 1'b0;
            end
            else if (base == CMRP_CMD_SKIP_FMT)
            begin
                nxt_accept = HAS_READ_OPT;
                nxt_reject = !HAS_READ_OPT;
                nxt_skip_fmt = HAS_READ_OPT;
                nxt_mark_fmt = 1'b0;
            end
            else if (base == CMRP_CMD_READ || base == CMRP_CMD_FEED)
            begin
                nxt_accept = 1'b1;
                nxt_fmt_on = cmd_code[CMRP_FMT_BIT];
                nxt_bin = cmd_code[CMRP_BIN_BIT];
                nxt_read_seen = (base == CMRP_CMD_READ);
            end
            else if (base == CMRP_CMD_WRFEED)
            begin
                nxt_accept = 1'b1;
                nxt_bypass = read_seen_ff;
                nxt_read_seen = 1'b0;
            end
            else
            begin
                nxt_reject = 1'b1;
            end
        end
        case (rd_st_ff)
            ST_IDLE:
            begin
                if (card_start)
                begin
                    nxt_marginal = 1'b0;
                    nxt_wptr = 8'h00;
                    nxt_short = short_card;
                    nxt_rd_st = ST_COPY;
                end
            end
            ST_COPY:
            begin
                if (col_valid)
                begin
                    if (fmt_on_ff && skip_fmt_ff && col_skip)
                    begin
                        wr_en = 1'b1;
                        wr_data = CMRP_BLANK;
                        nxt_wptr = wptr_ff + 8'h01;
                    end
                    else if (fmt_on_ff && mark_fmt_ff && !col_is_mark)
                    begin
                        wr_en = 1'b0;
                    end
                    else
                    begin
                        wr_en = 1'b1;
                        if (fmt_on_ff && mark_fmt_ff && col_unreadable)
                        begin
                            wr_data = CMRP_SUB_CODE;
                        end
                        nxt_wptr = wptr_ff + 8'h01;
                    end
                    if (fmt_on_ff && mark_fmt_ff && col_marginal)
                    begin
                        nxt_marginal = 1'b1;
                    end
                end
                if (card_end)
                begin
                    nxt_fill = wptr_ff;
                    nxt_rd_st = ST_FILL;
                end
            end
            ST_FILL:
            begin
                // pad the rest so stale data never shows
                if (fill_ff < last_idx(bin_ff, 1'b0))
                begin
                    wr_en = 1'b1;
                    wr_addr = fill_ff;
                    wr_data = CMRP_BLANK;
                    nxt_fill = fill_ff + 8'h01;
                end
                else
                begin
                    nxt_rd_st = ST_FLAG;
                end
            end
            ST_FLAG:
            begin
                wr_en = 1'b1;
                wr_addr = bin_ff ? CMRP_FLAG_IDX_BIN : CMRP_FLAG_IDX;
                wr_data = marginal_ff ? CMRP_SUB_CODE : CMRP_BLANK;
                nxt_rd_st = ST_IDLE;
            end
            default:
            begin
                nxt_rd_st = ST_IDLE;
            end
        endcase
        if (rd_st_ff == ST_COPY && wptr_ff > last_idx(bin_ff, short_ff))
        begin
            wr_en = 1'b0;
        end
    end

    always_comb
    begin
        nxt_ps_st = ps_st_ff;
        nxt_punch_req = 1'b0;
        nxt_stack_req = 1'b0;
        nxt_stk = stacker_sel_ff;
        nxt_light = stk3_light_ff;
        nxt_perr = punch_error_ff;
        nxt_busy = (ps_st_ff != PS_IDLE) && (ps_st_ff != PS_STOP);
        case (ps_st_ff)
            PS_IDLE:
            begin
                if (cmd_valid && base == CMRP_CMD_WRFEED)
                begin
                    nxt_punch_req = 1'b1;
                    nxt_ps_st = PS_PUNCH;
                end
            end
            PS_PUNCH:
            begin
                if (punch_done)
                begin
                    nxt_stack_req = 1'b1;
                    if (punch_bad && !bypass_ff)
                    begin
                        nxt_stk = CMRP_STK_ERROR;
                        nxt_punch_req = 1'b1;
                        nxt_ps_st = PS_RETRY;
                    end
                    else
                    begin
                        nxt_stk = CMRP_STK_NORMAL;
                        nxt_perr = punch_bad;
                        nxt_ps_st = PS_IDLE;
                    end
                end
            end
            PS_RETRY:
            begin
                if (punch_done)
                begin
                    nxt_stack_req = 1'b1;
                    if (punch_bad)
                    begin
                        nxt_stk = CMRP_STK_NORMAL;
                        nxt_perr = 1'b1;
                        nxt_ps_st = PS_STOP;
                    end
                    else
                    begin
                        nxt_stk = CMRP_STK_ERROR;
                        nxt_light = 1'b1;
                        nxt_punch_req = 1'b1;
                        nxt_ps_st = PS_EXTRA;
                    end
                end
            end
            PS_EXTRA:
            begin
                if (punch_done)
                begin
                    nxt_stack_req = 1'b1;
                    nxt_stk = CMRP_STK_NORMAL;
                    nxt_ps_st = PS_IDLE;
                end
            end
            PS_STOP:
            begin
                nxt_ps_st = PS_STOP;
            end
            default:
            begin
                nxt_ps_st = PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_st_ff <= ST_IDLE;
            ps_st_ff <= PS_IDLE;
            mark_fmt_ff <= 1'b0;
            skip_fmt_ff <= 1'b0;
            fmt_on_ff <= 1'b0;
            bin_ff <= 1'b0;
            short_ff <= 1'b0;
            marginal_ff <= 1'b0;
            read_seen_ff <= 1'b0;
            bypass_ff <= 1'b0;
            wptr_ff <= 8'h00;
            fill_ff <= 8'h00;
            cmd_reject_ff <= 1'b0;
            cmd_accept_ff <= 1'b0;
            punch_req_ff <= 1'b0;
            stack_req_ff <= 1'b0;
            stacker_sel_ff <= CMRP_STK_NORMAL;
            stk3_light_ff <= 1'b0;
            punch_error_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            rd_st_ff <= nxt_rd_st;
            ps_st_ff <= nxt_ps_st;
            mark_fmt_ff <= nxt_mark_fmt;
            skip_fmt_ff <= nxt_skip_fmt;
            fmt_on_ff <= nxt_fmt_on;
            bin_ff <= nxt_bin;
            short_ff <= nxt_short;
            marginal_ff <= nxt_marginal;
            read_seen_ff <= nxt_read_seen;
            bypass_ff <= nxt_bypass;
            wptr_ff <= nxt_wptr;
            fill_ff <= nxt_fill;
            cmd_reject_ff <= nxt_reject;
            cmd_accept_ff <= nxt_accept;
            punch_req_ff <= nxt_punch_req;
            stack_req_ff <= nxt_stack_req;
            stacker_sel_ff <= nxt_stk;
            stk3_light_ff <= nxt_light;
            punch_error_ff <= nxt_perr;
            busy_ff <= nxt_busy;
        end
    end

    a_pfr_reject: assert property (@(posedge sys_clk) disable iff (!rst_b)
        cmd_valid && base == CMRP_CMD_PFR |=> cmd_reject_ff && !cmd_accept_ff)
        else $error("punch feed read not rejected");
    a_retry_errstk: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ps_st_ff == PS_PUNCH && punch_done && punch_bad && !bypass_ff
        |=> stacker_sel_ff == CMRP_STK_ERROR && punch_req_ff)
        else $error("bad card not routed to error stacker");
    a_retry_good: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ps_st_ff == PS_RETRY && punch_done && !punch_bad
        |=> stk3_light_ff && stacker_sel_ff == CMRP_STK_ERROR)
        else $error("good retry card mishandled");
    a_retry_silent: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ps_st_ff == PS_PUNCH && punch_done && punch_bad && !bypass_ff
        |=> !punch_error_ff || $past(punch_error_ff))
        else $error("retry made visible");
    a_second_fail: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ps_st_ff == PS_RETRY && punch_done && punch_bad
        |=> punch_error_ff && stacker_sel_ff == CMRP_STK_NORMAL)
        else $error("second failure not reported");
    a_bypass_retry: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ps_st_ff == PS_PUNCH && punch_done && bypass_ff
        |=> ps_st_ff == PS_IDLE)
        else $error("retry not bypassed");
    a_sub_code: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_st_ff == ST_COPY && col_valid && fmt_on_ff && mark_fmt_ff
        && col_is_mark && col_unreadable && wr_en |-> wr_data == CMRP_SUB_CODE)
        else $error("unreadable column not substituted");
    a_flag_col: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_st_ff == ST_FLAG |-> wr_en && wr_data == (marginal_ff ?
        CMRP_SUB_CODE : CMRP_BLANK))
        else $error("flag column wrong");
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        rd_st_ff == ST_IDLE && card_start |=> !marginal_ff)
        else $error("marginal flag not cleared");
    a_mark_skip: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !(mark_fmt_ff && skip_fmt_ff))
        else $error("mark and skip formats both active");
endmodule : cmrp_ctrl
`default_nettype wire

/* File: tb/cmrp_host_model.sv */
/*
 host channel model: issues one command at a time, reads the card buffer.
 assumes the bench calls its tasks in sequence, never two at once.
*/
`timescale 1ns/1ps
`default_nettype none
module cmrp_host_model
(
    input wire logic sys_clk,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data_ff,
    input wire logic cmd_accept_ff,
    input wire logic cmd_reject_ff
);
    initial
    begin
        cmd_valid = 1'b0;
        cmd_code = 8'h00;
        rd_addr = 8'h00;
    end
    // code line scrambled when idle so a stale opcode cannot pass
    task automatic send(input logic [7:0] code, output logic acc,
                        output logic rej);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        cmd_code <= ~code;
        #1;
        acc = cmd_accept_ff;
        rej = cmd_reject_ff;
    endtask : send
    task automatic fetch(input logic [7:0] addr, output logic [7:0] d);
        @(posedge sys_clk);
        rd_addr <= addr;
        @(posedge sys_clk);
        #1;
        d = rd_data_ff;
    endtask : fetch
endmodule : cmrp_host_model
`default_nettype wire

/* File: tb/card_mark_read_punch_retry_bench.sv */
/*
 self-checking bench for the card control unit.
 assumes the host model drives commands and buffer reads.
*/
`timescale 1ns/1ps
`default_nettype none
module card_mark_read_punch_retry_bench;
    import cmrp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic cmd_valid, card_start, short_card, col_valid;
    logic col_is_mark, col_unreadable, col_marginal, card_end, col_skip;
    logic punch_done, punch_sense_raw, pos_skew_ok;
    logic [7:0] cmd_code, col_data, punch_expect, rd_addr, rd_data_ff;
    logic cmd_reject_ff, cmd_accept_ff, punch_req_ff, stack_req_ff;
    logic stk3_light_ff, punch_error_ff, busy_ff;
    logic [1:0] stacker_sel_ff;
    logic acc, rej;
    int error_cnt = 0;
    int checked = 0;
    always #12.5 sys_clk = ~sys_clk;
    initial
    begin
        {col_skip, card_start, short_card, col_valid, card_end} = 5'h00;
        {col_is_mark, col_unreadable, col_marginal} = 3'h0;
        {punch_done, punch_sense_raw, pos_skew_ok} = 3'h1;
        col_data = 8'h00;
        punch_expect = 8'h00;
    end
    cmrp_ctrl cmrp_ctrl_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .card_start(card_start), .short_card(short_card),
        .col_valid(col_valid), .col_is_mark(col_is_mark),
        .col_skip(col_skip), .col_unreadable(col_unreadable),
        .col_marginal(col_marginal), .col_data(col_data),
        .card_end(card_end), .punch_done(punch_done),
        .punch_sense_raw(punch_sense_raw), .punch_expect(punch_expect),
        .pos_skew_ok(pos_skew_ok), .rd_addr(rd_addr),
        .rd_data_ff(rd_data_ff), .cmd_reject_ff(cmd_reject_ff),
        .cmd_accept_ff(cmd_accept_ff), .punch_req_ff(punch_req_ff),
        .stacker_sel_ff(stacker_sel_ff), .stack_req_ff(stack_req_ff),
        .stk3_light_ff(stk3_light_ff), .punch_error_ff(punch_error_ff),
        .busy_ff(busy_ff));
    cmrp_host_model cmrp_host_model_inst (.sys_clk(sys_clk),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .rd_addr(rd_addr),
        .rd_data_ff(rd_data_ff), .cmd_accept_ff(cmd_accept_ff),
        .cmd_reject_ff(cmd_reject_ff));
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done();
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    task automatic do_reset();
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        #1;
        chk("stacker_sel reset", 8'h01, stacker_sel_ff);
        chk("busy reset", 8'h00, busy_ff);
    endtask : do_reset
    task automatic cmd(input logic [7:0] code, input logic r);
        cmrp_host_model_inst.send(code, acc, rej);
        chk("cmd_reject", r, rej);
        chk("cmd_accept", !r, acc);
    endtask : cmd
    task automatic card_open(input logic s);
        @(posedge sys_clk);
        card_start <= 1'b1;
        short_card <= s;
    endtask : card_open
    // flags are {mark, unreadable, marginal}
    task automatic col(input logic [2:0] f, input logic [7:0] d);
        @(posedge sys_clk);
        card_start <= 1'b0;
        col_valid <= 1'b1;
        {col_is_mark, col_unreadable, col_marginal} <= f;
        col_data <= d;
    endtask : col
    // fill of the blank tail needs up to 162 cycles before the next card
    task automatic card_close();
        @(posedge sys_clk);
        col_valid <= 1'b0;
        col_data <= ~col_data;
        card_end <= 1'b1;
        @(posedge sys_clk);
        card_end <= 1'b0;
        repeat (170) @(posedge sys_clk);
    endtask : card_close
    task automatic buf_is(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        cmrp_host_model_inst.fetch(a, d);
        chk("buffer byte", exp, d);
    endtask : buf_is
    // sense level settles through the two-flop synchroniser first
    task automatic punch(input logic good, input logic [1:0] sel,
                         input logic preq, input logic light);
        @(posedge sys_clk);
        punch_sense_raw <= good;
        punch_expect <= 8'h01;
        repeat (4) @(posedge sys_clk);
        punch_done <= 1'b1;
        @(posedge sys_clk);
        punch_done <= 1'b0;
        punch_expect <= 8'hFE;
        #1;
        chk("stack_req", 8'h01, stack_req_ff);
        chk("stacker_sel", sel, stacker_sel_ff);
        chk("punch_req", preq, punch_req_ff);
        chk("stk3_light", light, stk3_light_ff);
    endtask : punch
    task automatic t_cmds();
        logic [7:0] codes [5] = '{8'h02, 8'h0F, 8'h03, 8'h07, 8'h05};
        logic rejs [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 5; i++)
            cmd(codes[i], rejs[i]);
    endtask : t_cmds
    task automatic t_mark();
        cmd(CMRP_CMD_READ | 8'h20, 1'b0);
        card_open(1'b0);
        col(3'h4, 8'hC1);
        col(3'h0, 8'h40);
        col(3'h6, 8'h55);
        col(3'h0, 8'h40);
        col(3'h5, 8'hC3);
        card_close();
        buf_is(8'h00, 8'hC1);
        buf_is(8'h01, 8'h3F);
        buf_is(8'h02, 8'hC3);
        buf_is(8'h03, 8'h40);
        buf_is(8'h4F, 8'h3F);
        chk("punch_error", 8'h00, punch_error_ff);
    endtask : t_mark
    task automatic t_short();
        cmd(CMRP_CMD_READ, 1'b0);
        card_open(1'b1);
        for (int i = 0; i < 51; i++)
            col(3'h0, 8'hC5);
        card_close();
        buf_is(8'h00, 8'hC5);
        buf_is(8'h32, 8'hC5);
        buf_is(8'h33, 8'h40);
        buf_is(8'h4F, 8'h40);
    endtask : t_short
    task automatic t_bin();
        cmd(CMRP_CMD_MARK_FMT, 1'b0);
        cmd(CMRP_CMD_READ | 8'h60, 1'b0);
        card_open(1'b0);
        col(3'h6, 8'h11);
        col(3'h6, 8'h22);
        col(3'h5, 8'hC1);
        col(3'h5, 8'hC2);
        card_close();
        buf_is(8'h00, 8'h3F);
        buf_is(8'h01, 8'h3F);
        buf_is(8'h02, 8'hC1);
        buf_is(8'h03, 8'hC2);
        buf_is(8'h4F, 8'h40);
        buf_is(8'h9F, 8'h3F);
    endtask : t_bin
    task automatic t_skip();
        cmd(CMRP_CMD_SKIP_FMT, 1'b0);
        cmd(CMRP_CMD_READ | 8'h20, 1'b0);
        card_open(1'b0);
        col(3'h0, 8'hC7);
        col(3'h0, 8'hC8);
        col_skip <= 1'b1;
        col(3'h6, 8'hCA);
        col_skip <= 1'b0;
        card_close();
        buf_is(8'h00, 8'hC7);
        buf_is(8'h01, 8'h40);
        buf_is(8'h02, 8'hCA);
    endtask : t_skip
    // earlier reads would arm the read/punch bypass, so start clean
    task automatic t_retry();
        do_reset();
        cmd(CMRP_CMD_WRFEED, 1'b0);
        chk("punch_req", 8'h01, punch_req_ff);
        punch(1'b0, CMRP_STK_ERROR, 1'b1, 1'b0);
        chk("busy", 8'h01, busy_ff);
        punch(1'b1, CMRP_STK_ERROR, 1'b1, 1'b1);
        punch(1'b1, CMRP_STK_NORMAL, 1'b0, 1'b1);
        @(posedge sys_clk);
        #1;
        chk("busy", 8'h00, busy_ff);
        chk("punch_error", 8'h00, punch_error_ff);
    endtask : t_retry
    task automatic t_twofail();
        do_reset();
        cmd(CMRP_CMD_WRFEED, 1'b0);
        punch(1'b0, CMRP_STK_ERROR, 1'b1, 1'b0);
        punch(1'b0, CMRP_STK_NORMAL, 1'b0, 1'b0);
        chk("punch_error", 8'h01, punch_error_ff);
    endtask : t_twofail
    task automatic t_bypass();
        do_reset();
        cmd(CMRP_CMD_READ, 1'b0);
        cmd(CMRP_CMD_WRFEED, 1'b0);
        punch(1'b0, CMRP_STK_NORMAL, 1'b0, 1'b0);
        chk("punch_error", 8'h01, punch_error_ff);
    endtask : t_bypass
    initial
    begin
        do_reset();
        t_cmds();
        t_mark();
        t_short();
        t_bin();
        t_skip();
        t_retry();
        t_twofail();
        t_bypass();
        test_done();
    end
endmodule : card_mark_read_punch_retry_bench
`default_nettype wire
